// *** rtl/irq_map.vh ***
// Register offsets, field positions and vectors for the interrupt controller
`ifndef IRQ_MAP_VH
`define IRQ_MAP_VH
`define OFS_CORE 8'h00
`define OFS_SHARED 8'h04
`define OFS_SERIAL 8'h08
`define OFS_TIMER_A 8'h0C
`define OFS_TIMER_B 8'h10
`define OFS_MISC 8'h14
`define OFS_EDGE 8'h18
`define OFS_STACK 8'h1C
`define OFS_VECTOR 8'h20
`define RST_BYTE 8'h00
`define CORE_MASK 8'h7F
`define SHARED_MASK 8'hFF
`define SERIAL_MASK_S 8'h11
`define SERIAL_MASK_L 8'h33
`define TIMER_MASK_S 8'h33
`define TIMER_MASK_L 8'hFF
`define MISC_MASK 8'h33
`define EDGE_MASK 8'h0F
`define BIT_GIE 0
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define VEC_EXT0 12'h004
`define VEC_EXT1 12'h008
`define VEC_TICK0 12'h00C
`define VEC_TICK1 12'h010
`define VEC_SERIAL 12'h014
`define VEC_UART 12'h018
`define VEC_SHARED0 12'h01C
`define VEC_SHARED1 12'h020
`define VEC_SHARED2 12'h024
`endif

// *** rtl/irq_controller.v ***
// Vectored interrupt controller with AXI4-Lite register access
// Functional notes
// - A source event sets its pending flag regardless of its enable.
// - A pending flag is taken only when its own enable is set.
// - Global enable low blocks every interrupt.
// - Acceptance pushes the return address and loads the vector.
// - Return from interrupt pops the saved address.
// - Acceptance clears the global enable.
// - Requests while globally blocked still set their flags.
// - No acceptance while the hardware stack is full.
// - Any set pending flag wakes the core from sleep or idle.
// - Some sources own a vector; the rest share shared vectors.
// - Core register: tick0, ext1, ext0 flags 6..4; enables 3..0.
// - Shared register: shared2..0, tick1 flags 7..4; enables 3..0.
// - Serial register: serial 4/0, uart 5/1 in the large variant.
// - Timer A: compact flags 5,4 en 1,0; standard 7,6 en 3,2.
// - Timer B: periodic flags 5,4 en 1,0; timer-1 7,6 en 3,2.
// - Misc: eeprom flag 5, low voltage flag 4, enables 1 and 0.
// - Unimplemented bits read zero; all flags and enables reset zero.
// - Shared flag sets when any enabled member flag is set.
// - Servicing a shared request clears only the shared flag.
// - Servicing a pin or tick interrupt clears its own flag.
// - Edge field: 00 off, 01 rising, 10 falling, 11 both.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "irq_map.vh"
module irq_controller #(
  parameter LARGE = 1,
  parameter PC_W = 12,
  parameter DEPTH = 8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address, data and response
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // External pins
  input wire ext0_pin,
  input wire ext1_pin,
  // Peripheral events, one-cycle pulses
  input wire tick0_event,
  input wire tick1_event,
  input wire serial_event,
  input wire uart_event,
  input wire [3:0] timer_a_event,
  input wire [3:0] timer_b_event,
  input wire eeprom_done_event,
  input wire low_voltage_event,
  // Core sequencer
  input wire [PC_W-1:0] next_pc,
  input wire take_ready,
  input wire return_from_interrupt,
  output reg irq_take,
  output reg [PC_W-1:0] irq_vector,
  output reg [PC_W-1:0] return_pc,
  output reg stack_full,
  output wire wake
);
  localparam [7:0] SER_M = LARGE ? `SERIAL_MASK_L : `SERIAL_MASK_S;
  localparam [7:0] TMR_M = LARGE ? `TIMER_MASK_L : `TIMER_MASK_S;
  reg [7:0] core_q, shared_q, serial_q, tmr_a_q, tmr_b_q, misc_q, edge_q;
  reg [PC_W-1:0] stack_q [0:DEPTH-1];
  reg [3:0] sp_q;
  reg [7:0] core_d, shared_d, serial_d, tmr_a_d, tmr_b_d, misc_d;
  reg aw_q, w_q;
  reg [7:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  // Pin edge detection on the agreed synchronised levels
  function edge_hit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
      case (sel)
        `EDGE_RISE: edge_hit = cur & ~prev;
        `EDGE_FALL: edge_hit = ~cur & prev;
        `EDGE_BOTH: edge_hit = cur ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Pins pass three flops; a level counts once flops two and three agree
  wire [1:0] pin_in = {ext1_pin, ext0_pin};
  wire [1:0] pin_hit;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_pin
      reg [2:0] sync_q;
      reg level_q;
      wire agree = sync_q[1] == sync_q[2];
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync_q <= 3'h0;
          level_q <= 1'h0;
        end
        else
        begin
          sync_q <= {sync_q[1:0], pin_in[g]};
          if (agree)
            level_q <= sync_q[2];
        end
      end
      assign pin_hit[g] = agree
        & edge_hit(edge_q[2*g+1:2*g], sync_q[2], level_q);
    end
  endgenerate
  wire ext0_hit = pin_hit[0];
  wire ext1_hit = pin_hit[1];
  // Request priority: ext0, ext1, tick0, tick1, serial, uart, shared0..2
  wire [8:0] req;
  assign req[0] = core_q[4] & core_q[1];
  assign req[1] = core_q[5] & core_q[2];
  assign req[2] = core_q[6] & core_q[3];
  assign req[3] = shared_q[4] & shared_q[0];
  assign req[4] = serial_q[4] & serial_q[0];
  assign req[5] = serial_q[5] & serial_q[1];
  assign req[6] = shared_q[5] & shared_q[1];
  assign req[7] = shared_q[6] & shared_q[2];
  assign req[8] = shared_q[7] & shared_q[3];
  wire can_take = core_q[`BIT_GIE] & ~stack_full & take_ready;
  reg [8:0] grant;
  reg [PC_W-1:0] vec;
  integer i;
  always @*
  begin
    grant = 9'h000;
    vec = {PC_W{1'b0}};
    for (i = 8; i >= 0; i = i - 1)
      if (req[i])
      begin
        grant = 9'h000;
        grant[i] = 1'b1;
      end
    if (!can_take)
      grant = 9'h000;
    case (grant)
      9'h001: vec = `VEC_EXT0;
      9'h002: vec = `VEC_EXT1;
      9'h004: vec = `VEC_TICK0;
      9'h008: vec = `VEC_TICK1;
      9'h010: vec = `VEC_SERIAL;
      9'h020: vec = `VEC_UART;
      9'h040: vec = `VEC_SHARED0;
      9'h080: vec = `VEC_SHARED1;
      9'h100: vec = `VEC_SHARED2;
      default: vec = {PC_W{1'b0}};
    endcase
  end
  wire take = |grant;

  // Member flags AND enables feed the shared requests
  // They re-arm every cycle while a member stays set
  wire sh0_src = |(tmr_a_q[7:4] & tmr_a_q[3:0] & TMR_M[7:4]);
  wire sh1_src = |(tmr_b_q[7:4] & tmr_b_q[3:0] & TMR_M[7:4]);
  wire sh2_src = |(misc_q[5:4] & misc_q[1:0]);

  // Write channel handshake
  assign awready = ~aw_q & ~bvalid;
  assign wready = ~w_q & ~bvalid;
  wire [7:0] wa = aw_q ? awa_q : awaddr;
  wire [31:0] wdat = w_q ? wd_q : wdata;
  wire [3:0] wst = w_q ? ws_q : wstrb;
  wire have_aw = aw_q | (awvalid & awready);
  wire have_w = w_q | (wvalid & wready);
  wire do_wr = have_aw & have_w & ~bvalid;
  wire wr_ok = do_wr & wst[0];
  wire [7:0] wb = wdat[7:0];
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OFS_CORE) | (a == `OFS_SHARED) | (a == `OFS_SERIAL)
        | (a == `OFS_TIMER_A) | (a == `OFS_TIMER_B) | (a == `OFS_MISC)
        | (a == `OFS_EDGE) | (a == `OFS_STACK) | (a == `OFS_VECTOR);
    end
  endfunction
  // Pending-bit update: hardware set beats software and service clear
  function [7:0] upd;
    input [7:0] cur;
    input wr;
    input [7:0] wv;
    input [7:0] mask;
    input [7:0] hw_set;
    input [7:0] hw_clr;
    reg [7:0] t;
    begin
      t = wr ? wv : cur;
      t = t & ~hw_clr;
      upd = (t | hw_set) & mask;
    end
  endfunction

  // Register select for the write decode
  function sel;
    input [7:0] a;
    input [7:0] ofs;
    begin
      sel = a == ofs;
    end
  endfunction
  wire w_core = wr_ok & sel(wa, `OFS_CORE);
  wire w_shared = wr_ok & sel(wa, `OFS_SHARED);
  wire w_serial = wr_ok & sel(wa, `OFS_SERIAL);
  wire w_tmr_a = wr_ok & sel(wa, `OFS_TIMER_A);
  wire w_tmr_b = wr_ok & sel(wa, `OFS_TIMER_B);
  wire w_misc = wr_ok & sel(wa, `OFS_MISC);
  wire w_edge = wr_ok & sel(wa, `OFS_EDGE);
  wire [7:0] core_set = {1'b0, tick0_event, ext1_hit, ext0_hit, 4'h0};
  // Service clears own flag and global enable
  wire [7:0] core_clr = {1'b0, grant[2], grant[1], grant[0], 3'h0, take};
  wire [7:0] sh_set = {sh2_src, sh1_src, sh0_src, tick1_event, 4'h0};
  wire [7:0] sh_clr = {grant[8], grant[7], grant[6], grant[3], 4'h0};

  // Next flag and enable values
  always @*
  begin
    core_d = upd(core_q, w_core, wb, `CORE_MASK, core_set,
      core_clr);
    shared_d = upd(shared_q, w_shared, wb, `SHARED_MASK, sh_set,
      sh_clr);
    serial_d = upd(serial_q, w_serial, wb, SER_M,
      {2'h0, uart_event, serial_event, 4'h0}, 8'h00);
    tmr_a_d = upd(tmr_a_q, w_tmr_a, wb, TMR_M,
      {timer_a_event, 4'h0}, 8'h00);
    tmr_b_d = upd(tmr_b_q, w_tmr_b, wb, TMR_M,
      {timer_b_event, 4'h0}, 8'h00);
    misc_d = upd(misc_q, w_misc, wb, `MISC_MASK,
      {2'h0, eeprom_done_event, low_voltage_event, 4'h0},
      8'h00);
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_q <= `RST_BYTE;
      shared_q <= `RST_BYTE;
      serial_q <= `RST_BYTE;
      tmr_a_q <= `RST_BYTE;
      tmr_b_q <= `RST_BYTE;
      misc_q <= `RST_BYTE;
      edge_q <= `RST_BYTE;
    end
    else
    begin
      core_q <= core_d;
      shared_q <= shared_d;
      serial_q <= serial_d;
      tmr_a_q <= tmr_a_d;
      tmr_b_q <= tmr_b_d;
      misc_q <= misc_d;
      if (w_edge)
        edge_q <= wb & `EDGE_MASK;
    end
  end

  // Hardware stack and core handshake
  // A pop in a take cycle is dropped; the core never asks for both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sp_q <= 4'h0;
      stack_full <= 1'b0;
      irq_take <= 1'b0;
      irq_vector <= {PC_W{1'b0}};
      return_pc <= {PC_W{1'b0}};
    end
    else
    begin
      irq_take <= take;
      if (take)
      begin
        stack_q[sp_q[2:0]] <= next_pc;
        irq_vector <= vec;
        sp_q <= sp_q + 4'h1;
        stack_full <= (sp_q + 4'h1) == DEPTH[3:0];
      end
      else if (return_from_interrupt && sp_q != 4'h0)
      begin
        return_pc <= stack_q[sp_q[2:0] - 3'h1];
        sp_q <= sp_q - 4'h1;
        stack_full <= 1'b0;
      end
    end
  end
  assign wake = |{core_q[6:4], shared_q[7:4], serial_q[5:4],
    tmr_a_q[7:4], tmr_b_q[7:4], misc_q[5:4]};

  // Bus write response and read path
  // Writes answer one cycle after both channels are held
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h0;
    end
    else
    begin
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (do_wr)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else
      begin
        if (awvalid && awready)
        begin
          aw_q <= 1'b1;
          awa_q <= awaddr;
        end
        if (wvalid && wready)
        begin
          w_q <= 1'b1;
          wd_q <= wdata;
          ws_q <= wstrb;
        end
      end
      if (rvalid && rready)
        rvalid <= 1'b0;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr)
          `OFS_CORE: rdata <= {24'h0, core_q};
          `OFS_SHARED: rdata <= {24'h0, shared_q};
          `OFS_SERIAL: rdata <= {24'h0, serial_q};
          `OFS_TIMER_A: rdata <= {24'h0, tmr_a_q};
          `OFS_TIMER_B: rdata <= {24'h0, tmr_b_q};
          `OFS_MISC: rdata <= {24'h0, misc_q};
          `OFS_EDGE: rdata <= {24'h0, edge_q};
          `OFS_STACK: rdata <= {27'h0, stack_full, sp_q};
          `OFS_VECTOR: rdata <= {{(32-PC_W){1'b0}}, irq_vector};
          default: rdata <= 32'h0;
        endcase
      end
    end
  end
  assign arready = ~rvalid;
endmodule
`default_nettype wire

// *** bench/irq_controller_assertions.sv ***
// Port checks for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "irq_map.vh"
module irq_controller_assertions #(
  parameter PC_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  // Core side
  input wire logic take_ready,
  input wire logic irq_take,
  input wire logic [PC_W-1:0] irq_vector,
  input wire logic stack_full,
  input wire logic wake
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_TAKE_ONE: assert property (irq_take |=> !irq_take)
    else $error("long take");
  AST_FULL: assert property (stack_full |=> !irq_take)
    else $error("take when full");
  AST_READY: assert property (!take_ready |=> !irq_take)
    else $error("take when busy");
  AST_FLAG: assert property (irq_take |-> $past(wake))
    else $error("take without flag");
  AST_VEC: assert property (irq_take |-> irq_vector[1:0] == 2'h0
    && irq_vector >= `VEC_EXT0 && irq_vector <= `VEC_SHARED2)
    else $error("bad vector");
  AST_VEC_HOLD: assert property (!irq_take |-> $stable(irq_vector))
    else $error("vector moved");
  AST_WR: assert property (awvalid && awready && wvalid && wready
    |=> bvalid)
    else $error("no write answer");
  AST_BYTE: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper bits set");
  cover property (irq_take);
  cover property (stack_full);
  cover property (wake && !irq_take);
endmodule
bind irq_controller irq_controller_assertions #(.PC_W(PC_W)) u_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .rvalid, .rdata, .take_ready, .irq_take, .irq_vector, .stack_full,
  .wake);
`default_nettype wire

// *** bench/core_model.sv ***
// Core sequencer model: running pc, readiness, returns
`timescale 1ns/1ns
`default_nettype none
module core_model #(
  parameter PC_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench controls
  input wire logic stall,
  input wire logic pop_req,
  // Controller side
  output logic take_ready,
  output logic [PC_W-1:0] next_pc,
  output logic return_from_interrupt
);
  always @(posedge aclk)
    if (!aresetn)
    begin
      take_ready <= 1'h0;
      next_pc <= {PC_W{1'h0}};
      return_from_interrupt <= 1'h0;
    end
    else
    begin
      take_ready <= !stall;
      next_pc <= next_pc + 1'h1;
      return_from_interrupt <= pop_req;
    end
endmodule
`default_nettype wire

// *** bench/mcu_interrupt_controller_tb_top.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "irq_map.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %0t %0h %0h", $time, (g), (e)); end end
module mcu_interrupt_controller_tb_top;
  logic aclk, aresetn, stall, pop_req, awvalid, wvalid, bready;
  logic arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic irq_take, stack_full, wake, take_ready, return_from_interrupt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] pin, bresp, rresp;
  logic [13:0] ev;
  logic [11:0] next_pc, irq_vector, return_pc, pc_q;
  logic [11:0] stk[$];
  logic [7:0] msk[6] = '{8'h7F, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h33};
  logic [7:0] evx[6] = '{8'h40, 8'h10, 8'h30, 8'hF0, 8'hF0, 8'h30};
  int failures = 0;
  int comparisons = 0;
  irq_controller u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .ext0_pin(pin[0]), .ext1_pin(pin[1]), .tick0_event(ev[0]),
    .tick1_event(ev[1]), .serial_event(ev[2]), .uart_event(ev[3]),
    .timer_a_event(ev[7:4]), .timer_b_event(ev[11:8]),
    .eeprom_done_event(ev[12]), .low_voltage_event(ev[13]), .next_pc,
    .take_ready, .return_from_interrupt, .irq_take, .irq_vector,
    .return_pc, .stack_full, .wake);
  core_model u_core (.aclk, .aresetn, .stall, .pop_req, .take_ready,
    .next_pc, .return_from_interrupt);
  initial
  begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) pc_q <= next_pc;
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge aclk);
    failures++;
    end_sim();
  end
  task automatic io(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    {awvalid, wvalid, bready} <= {3{w}};
    {arvalid, rready} <= {2{!w}};
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (arready) arvalid <= 1'h0;
    end
    while (!(w ? bvalid : rvalid));
    {bready, rready} <= 2'h0;
    `CHK(w ? bresp : rresp, r)
    if (!w) `CHK(rdata, d)
  endtask
  task automatic pulse(input logic [13:0] v);
    ev <= v;
    @(posedge aclk);
    ev <= 14'h0;
  endtask
  task automatic wt(input logic [11:0] v);
    int n = 0;
    while (irq_take !== 1'h1 && n < 30)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK(irq_take, 1'h1)
    if (v != 12'h0) `CHK(irq_vector, v)
    stk.push_back(pc_q);
  endtask
  task automatic idle();
    repeat (10)
    begin
      @(posedge aclk);
      `CHK(irq_take, 1'h0)
    end
  endtask
  task automatic pop();
    logic [11:0] e;
    e = stk.pop_back();
    pop_req <= 1'h1;
    @(posedge aclk);
    pop_req <= 1'h0;
    repeat (2) @(posedge aclk);
    `CHK(return_pc, e)
  endtask
  task automatic t_regs();
    for (int i = 0; i < 6; i++) io(0, {i[5:0], 2'h0}, 32'h0);
    pulse(14'h3FFF);
    @(posedge aclk);
    `CHK(wake, 1'h1)
    for (int i = 0; i < 6; i++) io(0, {i[5:0], 2'h0}, evx[i]);
    for (int i = 0; i < 6; i++)
    begin
      io(1, {i[5:0], 2'h0}, 32'hFF);
      io(0, {i[5:0], 2'h0}, msk[i]);
    end
    for (int i = 5; i >= 0; i--) io(1, {i[5:0], 2'h0}, 32'h0);
    io(0, 8'h40, 32'h0, `RESP_SLVERR);
    `CHK(wake, 1'h0)
    stall <= 1'h0;
  endtask
  task automatic t_take();
    io(1, 8'h00, 32'h01);
    pulse(14'h1);
    idle();
    io(0, 8'h00, 32'h41);
    io(1, 8'h00, 32'h48);
    idle();
    io(1, 8'h00, 32'h49);
    wt(`VEC_TICK0);
    io(0, 8'h00, 32'h08);
    pop();
    io(1, 8'h00, 32'h37);
    wt(`VEC_EXT0);
    io(0, 8'h00, 32'h26);
    io(1, 8'h00, 32'h27);
    wt(`VEC_EXT1);
    pop();
    pop();
  endtask
  task automatic t_shared();
    io(1, 8'h14, 32'h01);
    io(1, 8'h04, 32'h0E);
    pulse(14'h2000);
    io(1, 8'h00, 32'h01);
    wt(`VEC_SHARED2);
    `CHK(irq_vector >= `VEC_SHARED0, 1'h1)
    io(0, 8'h14, 32'h11);
    io(1, 8'h14, 32'h00);
    io(1, 8'h04, 32'h00);
    pop();
  endtask
  task automatic t_edge();
    for (int s = 0; s < 4; s++)
    begin
      io(1, 8'h18, {28'h0, s[1:0], s[1:0]});
      pin <= 2'h3;
      repeat (6) @(posedge aclk);
      io(0, 8'h00, {26'h0, {2{s[0]}}, 4'h0});
      io(1, 8'h00, 32'h0);
      pin <= 2'h0;
      repeat (6) @(posedge aclk);
      io(0, 8'h00, {26'h0, {2{s[1]}}, 4'h0});
      io(1, 8'h00, 32'h0);
    end
  endtask
  task automatic t_stack();
    for (int k = 0; k < 8; k++)
    begin
      io(1, 8'h00, 32'h13);
      wt(`VEC_EXT0);
    end
    io(0, 8'h1C, 32'h18);
    `CHK(stack_full, 1'h1)
    io(1, 8'h00, 32'h13);
    idle();
    pop();
    wt(`VEC_EXT0);
    aresetn <= 1'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    io(0, 8'h1C, 32'h0);
    `CHK(stack_full, 1'h0)
  endtask
  initial
  begin
    {aresetn, pop_req, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    stall = 1'h1;
    ev = 14'h0;
    pin = 2'h0;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_take();
    t_shared();
    t_edge();
    t_stack();
    end_sim();
  end
endmodule
`default_nettype wire
